// *** logic/phy_mgmt_control_status.sv ***
// basic control and status registers of a 10/100 phy, with mgmt engine
// assumes mdc, mdio and mii tx pins are async; core signals on ref_clk
module phy_mgmt_control_status
  import phy_mgmt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // configuration straps, caught at reset
  input wire logic [4:0] phy_addr_strap,
  input wire logic autoneg_strap,
  input wire logic fast_full_duplex_strap,
  input wire logic slow_full_duplex_strap,
  // serial management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // mii transmit pins from the mac
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic mii_tx_er,
  // mii output pins toward the mac
  output logic mii_tx_clk,
  output logic mii_rx_clk,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic [3:0] mii_rxd,
  output logic mii_col,
  output logic mii_crs,
  output logic mii_out_oe,
  // core side of the mii
  input wire logic core_tx_clk,
  input wire logic core_rx_clk,
  input wire logic core_rx_dv,
  input wire logic core_rx_er,
  input wire logic [3:0] core_rxd,
  input wire logic core_col,
  input wire logic core_crs,
  output logic [3:0] core_txd,
  output logic core_tx_en,
  output logic core_tx_er,
  // line and led drivers
  output logic line_transmit_pair_oe,
  output logic led_oe,
  // phy core status
  input wire logic an_complete,
  input wire logic partner_remote_fault,
  input wire logic far_end_fault,
  input wire logic link_valid,
  input wire logic jabber,
  input wire logic speed_10,
  // phy core control
  output logic an_enable,
  output logic an_restart,
  output logic full_duplex,
  output logic powerdown,
  output logic collision_test
);
  typedef struct packed {
    mgmt_state_t state;
    logic [4:0] cnt;
    logic [15:0] shreg;
    logic [15:0] rd_data;
    logic [4:0] reg_addr;
    logic is_read;
    logic selected;
    logic mdio_out;
    logic mdio_oe;
    logic mdc_prev;
    logic [4:0] phy_addr;
    logic ctl_an_en;
    logic ctl_powerdown;
    logic ctl_isolate;
    logic ctl_restart;
    logic ctl_duplex;
    logic ctl_col_test;
    logic restart_pulse;
    logic an_done_prev;
    logic rf_q;
    logic link_q;
    logic jab_q;
    logic [3:0] txd;
    logic tx_en;
    logic tx_er;
    logic tx_clk;
    logic rx_clk;
    logic rx_dv;
    logic rx_er;
    logic [3:0] rxd;
    logic col;
    logic crs;
    logic out_oe;
  } bank_state_t;

  localparam int PIN_W = 8;
  localparam int STRAP_W = SYNC_W - PIN_W;

  bank_state_t s_q, s_d;
  logic [PIN_W-1:0] pins_s;
  logic [STRAP_W-1:0] straps_s;
  logic mdc_s, mdio_s, tx_en_s, tx_er_s;
  logic [3:0] txd_s;
  logic [4:0] addr_s;
  logic an_s, ffd_s, sfd_s;
  logic mdc_rise, rf_live, jab_live, an_done_rise, mii_iso;
  logic status_read, ctl_write;
  logic [15:0] status_word, control_word, hdr_word, wdata;

  // mgmt and mac pins
  sync_2ff #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .async_in({mdc, mdio_in, mii_tx_en, mii_tx_er, mii_txd}),
    .sync_out(pins_s)
  );

  // straps are caught on every ref_clk edge while reset is held low, so their sync must not be cleared
  sync_2ff #(
    .WIDTH(STRAP_W)
  ) u_strap_sync (
    .ref_clk(ref_clk),
    .async_in({phy_addr_strap, autoneg_strap, fast_full_duplex_strap,
               slow_full_duplex_strap}),
    .sync_out(straps_s)
  );

  assign {mdc_s, mdio_s, tx_en_s, tx_er_s, txd_s} = pins_s;
  assign {addr_s, an_s, ffd_s, sfd_s} = straps_s;

  always_comb begin
    s_d = s_q;
    s_d.restart_pulse = 1'b0;
    s_d.mdc_prev = mdc_s;
    s_d.an_done_prev = an_complete;
    mdc_rise = mdc_s & ~s_q.mdc_prev;
    an_done_rise = an_complete & ~s_q.an_done_prev;
    rf_live = partner_remote_fault | far_end_fault;
    jab_live = jabber & speed_10;
    status_read = 1'b0;
    ctl_write = 1'b0;
    hdr_word = {s_q.shreg[14:0], mdio_s};
    wdata = {s_q.shreg[14:0], mdio_s};

    // capability and ability bits are constants
    status_word = STS_FIXED;
    status_word[STS_AN_DONE] = s_q.ctl_an_en & an_complete;
    status_word[STS_REMOTE_FAULT] = s_q.rf_q;
    status_word[STS_LINK] = s_q.link_q;
    status_word[STS_JABBER] = s_q.jab_q;

    control_word = WORD_ZERO;
    control_word[CTL_AN_EN] = s_q.ctl_an_en;
    control_word[CTL_POWERDOWN] = s_q.ctl_powerdown;
    control_word[CTL_ISOLATE] = s_q.ctl_isolate;
    control_word[CTL_RESTART] = s_q.ctl_restart;
    control_word[CTL_DUPLEX] = s_q.ctl_duplex;
    control_word[CTL_COL_TEST] = s_q.ctl_col_test;

    // latches hold; a live event always wins over the read clear
    s_d.rf_q = s_q.rf_q | rf_live;
    s_d.link_q = s_q.link_q & link_valid;
    s_d.jab_q = s_q.jab_q | jab_live;

    if (an_done_rise) begin
      s_d.ctl_restart = 1'b0;
    end

    // engine never looks at isolate or powerdown
    if (mdc_rise) begin
      case (s_q.state)
        ST_HUNT: begin
          // preamble optional: any 0 after idle ones opens a frame
          s_d.mdio_oe = 1'b0;
          if (!mdio_s) begin
            s_d.state = ST_START;
          end
        end
        ST_START: begin
          if (mdio_s) begin
            s_d.state = ST_HDR;
            s_d.cnt = CNT_ZERO;
          end
        end
        ST_HDR: begin
          s_d.shreg = hdr_word;
          s_d.cnt = s_q.cnt + CNT_ONE;
          if (s_q.cnt == HDR_LAST) begin
            s_d.state = ST_TA;
            s_d.cnt = CNT_ZERO;
            s_d.reg_addr = hdr_word[4:0];
            s_d.is_read = hdr_word[11:10] == OP_READ;
            s_d.selected = hdr_word[9:5] == s_q.phy_addr &&
                           (hdr_word[11:10] == OP_READ ||
                            hdr_word[11:10] == OP_WRITE);
            s_d.rd_data = WORD_ZERO;
            if (s_d.selected && s_d.is_read) begin
              if (hdr_word[4:0] == REG_CONTROL) begin
                s_d.rd_data = control_word;
              end else if (hdr_word[4:0] == REG_STATUS) begin
                s_d.rd_data = status_word;
                status_read = 1'b1;
              end
            end
          end
        end
        ST_TA: begin
          s_d.cnt = s_q.cnt + CNT_ONE;
          if (s_q.selected && s_q.is_read) begin
            // first turnaround bit left floating, second driven low
            s_d.mdio_oe = 1'b1;
            s_d.mdio_out = 1'b0;
          end
          if (s_q.cnt == TA_LAST) begin
            s_d.state = ST_DATA;
            s_d.cnt = CNT_ZERO;
            s_d.mdio_out = s_q.rd_data[15];
            s_d.rd_data = {s_q.rd_data[14:0], 1'b0};
          end
        end
        ST_DATA: begin
          s_d.shreg = wdata;
          s_d.cnt = s_q.cnt + CNT_ONE;
          s_d.mdio_out = s_q.rd_data[15];
          s_d.rd_data = {s_q.rd_data[14:0], 1'b0};
          if (s_q.cnt == DATA_LAST) begin
            s_d.state = ST_HUNT;
            s_d.mdio_oe = 1'b0;
            s_d.mdio_out = 1'b0;
            ctl_write = s_q.selected && !s_q.is_read &&
                        s_q.reg_addr == REG_CONTROL;
          end
        end
        default: begin
          s_d.state = ST_HUNT;
          s_d.mdio_oe = 1'b0;
        end
      endcase
    end

    // read returned old values; reload from what is true now
    if (status_read) begin
      s_d.rf_q = rf_live;
      s_d.link_q = link_valid;
      s_d.jab_q = jab_live;
    end

    if (ctl_write) begin
      s_d.ctl_an_en = wdata[CTL_AN_EN];
      s_d.ctl_powerdown = wdata[CTL_POWERDOWN];
      s_d.ctl_isolate = wdata[CTL_ISOLATE];
      s_d.ctl_duplex = wdata[CTL_DUPLEX];
      s_d.ctl_col_test = wdata[CTL_COL_TEST];
      // placed after the completion clear so a new request wins
      if (wdata[CTL_RESTART] && wdata[CTL_AN_EN]) begin
        s_d.ctl_restart = 1'b1;
        s_d.restart_pulse = 1'b1;
      end
    end

    // powerdown implies isolation of the whole mii
    mii_iso = s_q.ctl_isolate | s_q.ctl_powerdown;
    s_d.out_oe = ~mii_iso;
    s_d.txd = mii_iso ? 4'h0 : txd_s;
    s_d.tx_en = ~mii_iso & tx_en_s;
    s_d.tx_er = ~mii_iso & tx_er_s;
    s_d.tx_clk = core_tx_clk;
    s_d.rx_clk = core_rx_clk;
    s_d.rx_dv = core_rx_dv;
    s_d.rx_er = core_rx_er;
    s_d.rxd = core_rxd;
    s_d.crs = core_crs;
    s_d.col = core_col | (s_q.ctl_col_test & tx_en_s);

    // park isolated outputs low: no stale level when the pads enable again
    if (mii_iso) begin
      s_d.tx_clk = 1'b0;
      s_d.rx_clk = 1'b0;
      s_d.rx_dv = 1'b0;
      s_d.rx_er = 1'b0;
      s_d.rxd = 4'h0;
      s_d.col = 1'b0;
      s_d.crs = 1'b0;
    end

    if (!reset_n) begin
      s_d = '0;
      s_d.state = ST_HUNT;
      s_d.ctl_powerdown = 1'b0;
      s_d.ctl_isolate = addr_s == ISOLATE_ADDR;
      s_d.ctl_an_en = an_s;
      s_d.ctl_duplex = ~an_s & (ffd_s | sfd_s);
      s_d.phy_addr = addr_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  // mdio pin
  assign mdio_out = s_q.mdio_out;
  assign mdio_oe = s_q.mdio_oe;
  // mii pins; clocks are sampled copies, good enough for isolation tests
  assign mii_tx_clk = s_q.tx_clk;
  assign mii_rx_clk = s_q.rx_clk;
  assign mii_rx_dv = s_q.rx_dv;
  assign mii_rx_er = s_q.rx_er;
  assign mii_rxd = s_q.rxd;
  assign mii_col = s_q.col;
  assign mii_crs = s_q.crs;
  assign mii_out_oe = s_q.out_oe;
  assign core_txd = s_q.txd;
  assign core_tx_en = s_q.tx_en;
  assign core_tx_er = s_q.tx_er;
  // drivers off during powerdown
  assign line_transmit_pair_oe = ~s_q.ctl_powerdown;
  assign led_oe = ~s_q.ctl_powerdown;
  assign an_enable = s_q.ctl_an_en;
  assign an_restart = s_q.restart_pulse;
  assign full_duplex = s_q.ctl_duplex;
  assign powerdown = s_q.ctl_powerdown;
  assign collision_test = s_q.ctl_col_test;
endmodule

// *** logic/phy_mgmt_pkg.sv ***
// constants for the basic control/status register bank and mgmt engine
// assumes a 16-bit register view reached over the serial mgmt pins
package phy_mgmt_pkg;
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam int CTL_AN_EN = 12;
  localparam int CTL_POWERDOWN = 11;
  localparam int CTL_ISOLATE = 10;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COL_TEST = 7;
  localparam int STS_AN_DONE = 5;
  localparam int STS_REMOTE_FAULT = 4;
  localparam int STS_LINK = 2;
  localparam int STS_JABBER = 1;
  // capability bits 14..11, 6, 3, 0 hardwired high
  localparam logic [15:0] STS_FIXED = 16'h7849;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] HDR_LAST = 5'h0B;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [4:0] ISOLATE_ADDR = 5'h00;
  localparam int SYNC_W = 16;

  typedef enum logic [2:0] {
    ST_HUNT = 3'b000,
    ST_START = 3'b001,
    ST_HDR = 3'b010,
    ST_TA = 3'b011,
    ST_DATA = 3'b100
  } mgmt_state_t;
endpackage

// *** logic/sync_2ff.sv ***
// two-flop synchroniser for a bundle of asynchronous pin levels
// assumes each bit is an independent level; no bus coherency implied
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic ref_clk,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s_q, s_d;

  // no reset: straps must flow through while reset is held low
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  assign sync_out = s_q.stable;
endmodule

// *** testbench/phy_mgmt_control_status_monitor.sv ***
// pin-level assertions for the control/status block
// assumes one ref_clk domain; bound into every instance below
module phy_mgmt_control_status_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // mii and line side
  input wire logic mii_out_oe,
  input wire logic line_transmit_pair_oe,
  input wire logic led_oe,
  input wire logic [3:0] core_txd,
  input wire logic core_tx_en,
  input wire logic mii_tx_en,
  input wire logic core_crs,
  input wire logic mii_crs,
  input wire logic mii_col,
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_er,
  input wire logic core_tx_er,
  input wire logic mii_tx_clk,
  input wire logic mii_rx_clk,
  input wire logic mii_rx_dv,
  input wire logic mii_rx_er,
  input wire logic [3:0] mii_rxd,
  input wire logic core_tx_clk,
  input wire logic core_rx_clk,
  input wire logic core_rx_dv,
  input wire logic core_rx_er,
  input wire logic [3:0] core_rxd,
  // control outputs
  input wire logic powerdown,
  input wire logic collision_test,
  input wire logic an_enable,
  input wire logic an_restart,
  // management pins
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  property p_pd_off;
    powerdown |=> !line_transmit_pair_oe && !led_oe && !mii_out_oe;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("powerdown left a driver on");
  // reset must win even while reset is low, so no disable here
  property p_pd_clr;
    disable iff (1'h0) !reset_n |=> !powerdown;
  endproperty
  a_pd_clr: assert property (p_pd_clr)
    else $error("reset kept powerdown");
  property p_iso_tx;
    !mii_out_oe |-> !core_tx_en && !core_tx_er && core_txd == 4'h0;
  endproperty
  a_iso_tx: assert property (p_iso_tx)
    else $error("tx passed while isolated");
  property p_tx_pass;
    mii_out_oe |-> {core_tx_en, core_tx_er, core_txd} ==
      $past({mii_tx_en, mii_tx_er, mii_txd}, 3);
  endproperty
  a_tx_pass: assert property (p_tx_pass)
    else $error("tx pins not passed through");
  property p_crs;
    mii_out_oe && $past(mii_out_oe) |->
      {mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_rx_er, mii_rxd, mii_crs} ==
      $past({core_tx_clk, core_rx_clk, core_rx_dv, core_rx_er, core_rxd,
      core_crs});
  endproperty
  a_crs: assert property (p_crs)
    else $error("crs copy wrong");
  property p_col;
    (collision_test && mii_tx_en && mii_out_oe)[*4] |-> mii_col;
  endproperty
  a_col: assert property (p_col)
    else $error("collision test not echoed");
  property p_rs_en;
    an_restart |-> an_enable;
  endproperty
  a_rs_en: assert property (p_rs_en)
    else $error("restart without autoneg");
  property p_rs_one;
    an_restart |=> !an_restart;
  endproperty
  a_rs_one: assert property (p_rs_one)
    else $error("restart pulse too long");
  property p_ta;
    $rose(mdio_oe) |-> !mdio_out;
  endproperty
  a_ta: assert property (p_ta)
    else $error("turnaround not zero");
endmodule

bind phy_mgmt_control_status phy_mgmt_control_status_monitor i_mon (
  .ref_clk, .reset_n, .mii_out_oe, .line_transmit_pair_oe, .led_oe,
  .core_txd, .core_tx_en, .mii_tx_en, .core_crs, .mii_crs, .mii_col,
  .mii_txd, .mii_tx_er, .core_tx_er, .mii_tx_clk, .mii_rx_clk, .mii_rx_dv,
  .mii_rx_er, .mii_rxd, .core_tx_clk, .core_rx_clk, .core_rx_dv,
  .core_rx_er, .core_rxd,
  .powerdown, .collision_test, .an_enable, .an_restart, .mdio_out,
  .mdio_oe);

// *** testbench/phy_mgmt_control_status_tb.sv ***
// self-checking bench for the basic control/status registers
// assumes smc_model and the bound monitor are compiled first
module phy_mgmt_control_status_tb
  import phy_mgmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0, reset_n = 1'h0, pre = 1'h1, mdc, mdio_in;
  logic [4:0] phy_addr_strap = 5'h01, addr = 5'h01;
  logic autoneg_strap = 1'h0, fast_full_duplex_strap = 1'h0;
  logic slow_full_duplex_strap = 1'h0, mii_tx_en = 1'h0, mii_tx_er = 1'h0;
  logic [3:0] mii_txd = 4'h0, core_rxd = 4'h0, core_txd, mii_rxd;
  logic core_tx_clk = 1'h0, core_rx_clk = 1'h0, core_rx_dv = 1'h0;
  logic core_rx_er = 1'h0, core_col = 1'h0, core_crs = 1'h0;
  logic an_complete = 1'h0, partner_remote_fault = 1'h0, jabber = 1'h0;
  logic far_end_fault = 1'h0, link_valid = 1'h0, speed_10 = 1'h0;
  logic m_drv, m_en, mdio_out, mdio_oe, mii_tx_clk, mii_rx_clk, mii_rx_dv;
  logic mii_rx_er, mii_col, mii_crs, mii_out_oe, core_tx_en, core_tx_er;
  logic line_transmit_pair_oe, led_oe, an_enable, an_restart;
  logic full_duplex, powerdown, collision_test;
  int i, fail_count = 0, checks_done = 0;

  phy_mgmt_control_status i_dut (.*);
  smc_model i_smc (.ref_clk(ref_clk), .mdio_line(mdio_in), .mdc(mdc),
    .mdio_drv(m_drv), .mdio_en(m_en));
  // pull-up: a released line reads high
  assign mdio_in = mdio_oe ? mdio_out : (m_en ? m_drv : 1'h1);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    {core_tx_clk, core_rx_clk, core_rx_dv, core_rx_er} <= 4'($urandom);
    {core_rxd, core_crs, mii_txd, mii_tx_er} <= 10'($urandom);
  end

  function automatic logic [15:0] sw(input logic [3:0] b);
    return STS_FIXED | {10'h000, b[3:2], 1'h0, b[1:0], 1'h0};
  endfunction
  function automatic logic [15:0] reset_ctl();
    return {3'h0, autoneg_strap, 1'h0, addr == 5'h00, 1'h0,
      !autoneg_strap && (fast_full_duplex_strap || slow_full_duplex_strap),
      8'h00};
  endfunction
  task automatic check(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] ra,
    input logic [15:0] v);
    logic [15:0] d;
    i_smc.xfer(w, addr, ra, v, pre, d);
    pre = 1'h0;
    if (!w)
      check(d, v);
  endtask
  task automatic pulse(input logic [3:0] v);
    {link_valid, partner_remote_fault, far_end_fault, jabber} <= v;
    repeat (3) @(posedge ref_clk);
    {link_valid, partner_remote_fault, far_end_fault, jabber} <= 4'h8;
    @(posedge ref_clk);
  endtask
  task automatic do_reset(input logic [4:0] pa);
    @(posedge ref_clk);
    reset_n <= 1'h0;
    phy_addr_strap <= pa;
    {autoneg_strap, fast_full_duplex_strap, slow_full_duplex_strap}
      <= 3'($urandom);
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    addr = pa;
    pre = 1'h1;
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hf618_26e7));
    for (i = 0; i < 4; i++) begin
      do_reset(5'h01 + 5'($urandom_range(30)));
      acc(1'h0, REG_CONTROL, reset_ctl());
      acc(1'h0, REG_STATUS, sw(4'h0));
      check(16'(an_enable), 16'(autoneg_strap));
    end
    $display("test straps done");
    speed_10 <= 1'h1;
    pulse(4'hd);
    acc(1'h0, REG_STATUS, sw(4'h5));
    acc(1'h0, REG_STATUS, sw(4'h2));
    speed_10 <= 1'h0;
    pulse(4'h3);
    acc(1'h0, REG_STATUS, sw(4'h4));
    acc(1'h0, REG_STATUS, sw(4'h2));
    $display("test latches done");
    mii_tx_en <= 1'h1;
    acc(1'h1, REG_CONTROL, 16'he5ff);
    check(16'(mii_out_oe), 16'h0000);
    check(16'(core_tx_en), 16'h0000);
    acc(1'h0, REG_CONTROL, 16'h0580);
    for (i = 0; i < 2; i++) begin
      acc(1'h1, REG_CONTROL, 16'h0080 | 16'(i) << 8);
      check(16'(full_duplex), 16'(i));
      check(16'(mii_col), 16'h0001);
      check(16'(core_tx_en), 16'h0001);
    end
    $display("test isolate done");
    acc(1'h1, REG_CONTROL, 16'h0200);
    acc(1'h0, REG_CONTROL, 16'h0000);
    acc(1'h1, REG_CONTROL, 16'h1200);
    acc(1'h0, REG_CONTROL, 16'h1200);
    an_complete <= 1'h1;
    acc(1'h0, REG_CONTROL, 16'h1000);
    acc(1'h0, REG_STATUS, sw(4'ha));
    $display("test restart done");
    acc(1'h0, 5'h05, 16'h0000);
    addr = addr + 5'h01;
    acc(1'h0, REG_STATUS, 16'hffff);
    addr = addr - 5'h01;
    $display("test refused done");
    acc(1'h1, REG_CONTROL, 16'h0800);
    check(16'(line_transmit_pair_oe | led_oe), 16'h0000);
    check(16'(mii_out_oe), 16'h0000);
    do_reset(5'h00);
    check(16'(powerdown), 16'h0000);
    check(16'(line_transmit_pair_oe), 16'h0001);
    check(16'(mii_out_oe), 16'h0000);
    acc(1'h0, REG_CONTROL, reset_ctl());
    $display("test powerdown done");
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    $display("[ERR] %0t: run limit reached", $time);
    give_verdict();
  end
endmodule

// *** testbench/smc_model.sv ***
// station management controller: drives mdc/mdio frames
// assumes the bench resolves mdio with a pull-up when released
module smc_model
  import phy_mgmt_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // management pins
  input wire logic mdio_line,
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    mdc = 1'h0;
    mdio_drv = 1'h1;
    mdio_en = 1'h0;
  end
  // mdc stands low between frames; 800 ns bit time
  task automatic xfer(input logic wr, input logic [4:0] pa, ra,
    input logic [15:0] wd, input logic pre, output logic [15:0] rd);
    logic [64:0] f;
    int k;
    // trailing 1 is a clocked idle bit with the line released
    f = {32'hffff_ffff, 2'h1, wr ? OP_WRITE : OP_READ, pa, ra, 2'h2, wd,
      1'h1};
    rd = 16'h0000;
    @(posedge ref_clk);
    for (k = pre ? 64 : 32; k >= 0; k--) begin
      mdio_en <= k > 0 && (wr || k > 18);
      mdio_drv <= f[k];
      repeat (4) @(posedge ref_clk);
      if (!wr && k > 0 && k < 17)
        rd = {rd[14:0], mdio_line};
      mdc <= 1'h1;
      repeat (4) @(posedge ref_clk);
      mdc <= 1'h0;
    end
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
